// [verilog/pxs_defs.svh]
// Constants for the port expander serial slave
`ifndef PXS_DEFS_SVH
`define PXS_DEFS_SVH

`define PXS_DEV_ADDR_LOW 8'h82
`define PXS_DEV_ADDR_HIGH 8'h88
`define PXS_LAST_DATA_BIT 4'h7
`define PXS_ACK_BIT 4'h8
`define PXS_BIT_FIRST 4'h0
`define PXS_CORE_PERIOD_NS 40
`define PXS_T_HIGH_MIN_NS 600
`define PXS_T_HIGH_MIN_CYC ((`PXS_T_HIGH_MIN_NS + `PXS_CORE_PERIOD_NS - 1) / `PXS_CORE_PERIOD_NS)

`endif

// [verilog/pxs_pkg.sv]
// Types shared by the port expander serial slave
package pxs_pkg;

	typedef enum logic [3:0] {
		PXS_ADDR = 4'b0001,
		PXS_WRITE = 4'b0010,
		PXS_READ = 4'b0100,
		PXS_IGNORE = 4'b1000
	} pxs_phase_t;

	typedef struct packed {
		logic reg_addr;
		logic [7:0] data;
	} pxs_wr_t;

endpackage : pxs_pkg

// [verilog/pxs_slave.sv]
// Serial slave interface of an 8-bit port expander
// What this block does
// RULE_01: Address-select pin low answers address 0x82, high answers 0x88.
// RULE_02: Direction bit 1 means read, 0 means write.
// RULE_03: Master sends start, then address byte with direction bit.
// RULE_04: On address match, pull data line low in ninth clock.
// RULE_05: On mismatch, stay released, no acknowledge, ignore rest of transaction.
// RULE_06: Start is data falling while clock high.
// RULE_07: Always watch for start; ignore all bus activity before one.
// RULE_08: Stop is data rising while clock high; ends communication.
// RULE_09: After stop, return idle and ready for next transaction.
// RULE_10: Master ends a read by not acknowledging, then may stop.
// RULE_11: Stop ends a write; no more bytes stored until new transaction.
// RULE_12: Transmitter releases after eight bits; receiver pulls low in ninth.
// RULE_13: A receiver not acknowledging leaves data line high.
// RULE_14: Incoming data bits are sampled on serial clock rising edge.
// RULE_15: Data changes only while clock low, except start and stop.
// RULE_16: Works at 100 kbit/s and 400 kbit/s.
// RULE_17: Write sends register address byte, then data bytes, then stop.
// RULE_18: In a read, no acknowledge from master returns device to idle.
// RULE_19: Start mid-transaction resets counters and restarts address reception.
// RULE_20: Data line released except while acknowledging or sending read data.
`timescale 1ns/10ps
`include "pxs_defs.svh"

module pxs_slave
	import pxs_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_resetn,
	input wire logic i_scl_clk,
	input wire logic i_serial_data_line,
	output logic o_serial_data_line,
	output logic o_serial_data_line_oe,
	input wire logic i_address_select_pin,
	output logic o_wr_valid,
	output pxs_wr_t o_wr,
	output logic o_rd_req,
	input wire logic [7:0] i_rd_data
);

	// Core domain: line synchronisers and frame detection
	logic scl_s1;
	logic scl_s2;
	logic scl_prev;
	logic sda_s1;
	logic sda_s2;
	logic sda_prev;
	logic sel_s1;
	logic sel_s2;
	logic [1:0] strap_wait;
	logic strap_taken;
	logic strap;
	logic start_seen;
	logic stop_seen;
	logic link_rst_n;
	logic restart_armed;

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			scl_s1 <= 1'b1;
			scl_s2 <= 1'b1;
			scl_prev <= 1'b1;
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
			sda_prev <= 1'b1;
		end else begin
			scl_s1 <= i_scl_clk;
			scl_s2 <= scl_s1;
			scl_prev <= scl_s2;
			sda_s1 <= i_serial_data_line;
			sda_s2 <= sda_s1;
			sda_prev <= sda_s2;
		end
	end

	// Strap is caught once after reset release and held
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			sel_s1 <= 1'b0;
			sel_s2 <= 1'b0;
			strap_wait <= 2'h0;
			strap_taken <= 1'b0;
			strap <= 1'b0;
		end else begin
			sel_s1 <= i_address_select_pin;
			sel_s2 <= sel_s1;
			// Wait out both synchroniser stages, else the reset value is latched
			strap_wait <= {strap_wait[0], 1'b1};
			if (strap_wait[1] && !strap_taken) begin
				strap_taken <= 1'b1;
				strap <= sel_s2; // see RULE_01
			end
		end
	end

	assign start_seen = sda_prev & ~sda_s2 & scl_s2 & scl_prev; // see RULE_06
	assign stop_seen = ~sda_prev & sda_s2 & scl_s2 & scl_prev; // see RULE_08

	// The link logic is held in reset outside frames, so it counts on no
	// clock edge before a start; a start re-arms it once the clock is low.
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			link_rst_n <= 1'b0;
			restart_armed <= 1'b0;
		end else if (start_seen) begin
			link_rst_n <= 1'b0; // see RULE_07 see RULE_19
			restart_armed <= 1'b1;
		end else if (stop_seen) begin
			link_rst_n <= 1'b0; // see RULE_09 see RULE_11
			restart_armed <= 1'b0;
		end else if (restart_armed && !scl_s2) begin
			link_rst_n <= 1'b1;
			restart_armed <= 1'b0;
		end
	end

	// Link domain, clocked by the serial clock
	pxs_phase_t phase;
	logic [3:0] bit_cnt;
	logic [6:0] shift_in;
	logic [7:0] byte_full;
	logic ack_ok;
	logic first_data;
	logic own_s1;
	logic own_s2;
	logic [7:0] own_addr;
	logic wr_tgl;
	pxs_wr_t wr_hold;
	logic rd_tgl;
	logic [7:0] rd_hold;
	logic [6:0] tx_shift;
	logic wr_event;
	logic rd_event;

	assign byte_full = {shift_in, i_serial_data_line};
	assign own_addr = own_s2 ? `PXS_DEV_ADDR_HIGH : `PXS_DEV_ADDR_LOW; // see RULE_01

	// Strap settles in two serial edges, well before the address byte ends
	always_ff @(posedge i_scl_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			own_s1 <= 1'b0;
			own_s2 <= 1'b0;
		end else begin
			own_s1 <= strap;
			own_s2 <= own_s1;
		end
	end

	always_ff @(posedge i_scl_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			bit_cnt <= `PXS_BIT_FIRST; // see RULE_19
		end else if (bit_cnt == `PXS_ACK_BIT) begin
			bit_cnt <= `PXS_BIT_FIRST;
		end else begin
			bit_cnt <= bit_cnt + 4'h1;
		end
	end

	always_ff @(posedge i_scl_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			shift_in <= 7'h00;
		end else if (bit_cnt != `PXS_ACK_BIT) begin
			shift_in <= byte_full[6:0]; // see RULE_14
		end
	end

	always_ff @(posedge i_scl_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			phase <= PXS_ADDR;
			ack_ok <= 1'b0;
			first_data <= 1'b1;
		end else begin
			unique case (phase)
				PXS_ADDR: begin
					if (bit_cnt == `PXS_LAST_DATA_BIT) begin
						ack_ok <= (byte_full[7:1] == own_addr[7:1]); // see RULE_04
					end else if (bit_cnt == `PXS_ACK_BIT) begin
						if (!ack_ok) begin
							phase <= PXS_IGNORE; // see RULE_05
						end else if (shift_in[0]) begin
							// Direction bit; byte_full[0] already holds the ack level
							phase <= PXS_READ; // see RULE_02
						end else begin
							phase <= PXS_WRITE; // see RULE_02
						end
					end
				end
				PXS_WRITE: begin
					if (bit_cnt == `PXS_LAST_DATA_BIT) begin
						ack_ok <= 1'b1;
						first_data <= 1'b0;
					end
				end
				PXS_READ: begin
					if (bit_cnt == `PXS_ACK_BIT) begin
						if (i_serial_data_line) begin
							phase <= PXS_IGNORE; // see RULE_18 see RULE_13
						end
					end
				end
				PXS_IGNORE: begin
					ack_ok <= 1'b0;
				end
			endcase
		end
	end

	// Event toggles are reset only with the core, never by the frame reset:
	// a start or stop clearing them would look like a new byte to the core.
	assign wr_event = (phase == PXS_WRITE) && (bit_cnt == `PXS_LAST_DATA_BIT);
	assign rd_event = (bit_cnt == `PXS_ACK_BIT) &&
		((phase == PXS_ADDR && ack_ok && shift_in[0]) ||
		(phase == PXS_READ && !i_serial_data_line)); // see RULE_02 see RULE_18

	always_ff @(posedge i_scl_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			wr_tgl <= 1'b0;
			wr_hold <= '0;
			rd_tgl <= 1'b0;
		end else begin
			if (wr_event) begin
				wr_hold <= '{reg_addr: first_data, data: byte_full}; // see RULE_17
				wr_tgl <= ~wr_tgl;
			end
			if (rd_event) begin
				rd_tgl <= ~rd_tgl;
			end
		end
	end

	// Drive on the falling edge so the line is stable across every rising edge
	always_ff @(negedge i_scl_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			o_serial_data_line_oe <= 1'b0; // see RULE_20
			tx_shift <= 7'h00;
		end else if (bit_cnt == `PXS_ACK_BIT) begin
			o_serial_data_line_oe <= ack_ok && (phase == PXS_ADDR || phase == PXS_WRITE); // see RULE_04 see RULE_12
			tx_shift <= tx_shift;
		end else if (phase == PXS_READ && bit_cnt == `PXS_BIT_FIRST) begin
			o_serial_data_line_oe <= ~rd_hold[7]; // see RULE_15
			tx_shift <= rd_hold[6:0];
		end else if (phase == PXS_READ) begin
			o_serial_data_line_oe <= ~tx_shift[6]; // see RULE_15
			tx_shift <= {tx_shift[5:0], 1'b1};
		end else begin
			o_serial_data_line_oe <= 1'b0; // see RULE_20 see RULE_12
			tx_shift <= tx_shift;
		end
	end

	// Open drain: only ever pulls low
	assign o_serial_data_line = 1'b0;

	// Event crossings back to the core; the hold words are stable for a
	// whole byte time, far longer than the three-cycle toggle path.
	logic wr_s1;
	logic wr_s2;
	logic wr_prev;
	logic rd_s1;
	logic rd_s2;
	logic rd_prev;

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			wr_s1 <= 1'b0;
			wr_s2 <= 1'b0;
			wr_prev <= 1'b0;
			rd_s1 <= 1'b0;
			rd_s2 <= 1'b0;
			rd_prev <= 1'b0;
		end else begin
			wr_s1 <= wr_tgl;
			wr_s2 <= wr_s1;
			wr_prev <= wr_s2;
			rd_s1 <= rd_tgl;
			rd_s2 <= rd_s1;
			rd_prev <= rd_s2;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_wr_valid <= 1'b0;
			o_wr <= '0;
		end else begin
			o_wr_valid <= wr_s2 ^ wr_prev;
			if (wr_s2 ^ wr_prev) begin
				o_wr <= wr_hold;
			end
		end
	end

	// Read byte is fetched at the ack rising edge; it is needed only at the
	// next falling edge, at least a clock-high time later (RULE_16 margin).
	assign o_rd_req = rd_s2 ^ rd_prev;

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rd_hold <= 8'h00;
		end else if (o_rd_req) begin
			rd_hold <= i_rd_data; // see RULE_16
		end
	end

endmodule : pxs_slave

// [dv/pxs_slave_properties.sv]
// Checker of the serial slave port behaviour
`timescale 1ns/10ps
module pxs_slave_properties
	import pxs_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_resetn,
	input wire logic i_scl_clk,
	input wire logic i_serial_data_line,
	input wire logic o_serial_data_line,
	input wire logic o_serial_data_line_oe,
	input wire logic i_address_select_pin,
	input wire logic o_wr_valid,
	input wire pxs_wr_t o_wr,
	input wire logic o_rd_req,
	input wire logic [7:0] i_rd_data
);
	wire oe = o_serial_data_line_oe;
	default clocking @(posedge i_core_clk);
	endclocking
	default disable iff (!i_resetn);
	AST_OD_LOW: assert property (!o_serial_data_line) else $error("od high");
	AST_WR_PULSE: assert property (o_wr_valid |=> !o_wr_valid) else $error("wr");
	AST_RD_PULSE: assert property (o_rd_req |=> !o_rd_req) else $error("rd");
	AST_OE_RISE: assert property ($rose(oe) |-> !i_scl_clk) else $error("oe up");
	AST_OE_FALL: assert property ($fell(oe) |-> !i_scl_clk) else $error("oe dn");
	AST_OE_HOLD: assert property ($rose(oe) |-> oe[*8]) else $error("oe hold");
	AST_WR_RISE: assert property (o_wr_valid |-> i_scl_clk && !oe) else $error("wr");
	AST_RD_RISE: assert property (o_rd_req |-> i_scl_clk) else $error("rd");
	cover property (o_wr_valid && o_wr.reg_addr);
	cover property (o_rd_req);
	cover property ($fell(oe));
endmodule : pxs_slave_properties

bind pxs_slave pxs_slave_properties u_props (.*);

// [dv/pxs_host_model.sv]
// Bus master model driving the serial clock and pulling the data line
`timescale 1ns/10ps
module pxs_host_model (
	output logic o_scl_clk,
	output logic o_pull_low,
	input wire logic i_sda
);
	// Bit time scale: 1 near fast mode, 4 near standard mode
	int k = 1;
	initial begin
		o_scl_clk = 1'b1;
		o_pull_low = 1'b0;
	end
	// Data moves only while the clock is low, held past the fall
	task automatic bit_io(input logic b, output logic r);
		#(96 * k);
		o_pull_low = !b;
		#(1296 * k);
		o_scl_clk = 1'b1;
		#(1248 * k);
		r = i_sda;
		o_scl_clk = 1'b0;
	endtask : bit_io
	task automatic start();
		o_pull_low = 1'b0;
		#(1296 * k);
		o_scl_clk = 1'b1;
		#(1248 * k);
		o_pull_low = 1'b1;
		#(1248 * k);
		o_scl_clk = 1'b0;
	endtask : start
	task automatic stop();
		#(96 * k);
		o_pull_low = 1'b1;
		#(1248 * k);
		o_scl_clk = 1'b1;
		#(1248 * k);
		o_pull_low = 1'b0;
		#(1344 * k);
	endtask : stop
	// Ninth bit of d is the level the master leaves during acknowledge
	task automatic xfer(input logic [8:0] d, output logic [8:0] r);
		for (int i = 8; i >= 0; i--) begin
			bit_io(d[i], r[i]);
		end
	endtask : xfer
endmodule : pxs_host_model

// [dv/tb_pxs_slave.sv]
// Self-checking bench of the serial slave
`timescale 1ns/10ps
module tb_pxs_slave;
	import pxs_pkg::*;
	logic i_core_clk = 1'b0;
	logic i_resetn = 1'b0;
	logic sel = 1'b0;
	logic [7:0] rd_data = 8'h96;
	logic scl, pull_low, oe, od, wr_valid, rd_req;
	logic [8:0] r;
	pxs_wr_t wr, last_wr;
	int errors = 0;
	int cmp_count = 0;
	int wr_n = 0;
	int rd_n = 0;
	// Row: strap, address byte, data byte, acknowledge expected
	logic [17:0] rows [4] = '{{1'b0, 8'h88, 8'h3c, 1'b0}, {1'b1, 8'h82, 8'h0f, 1'b0},
		{1'b0, 8'h82, 8'ha5, 1'b1}, {1'b1, 8'h88, 8'hc3, 1'b1}};
	wire sda = !pull_low && !(oe && !od);
	always #20 i_core_clk = ~i_core_clk;
	pxs_slave dut (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_scl_clk(scl),
		.i_serial_data_line(sda), .o_serial_data_line(od), .o_serial_data_line_oe(oe),
		.i_address_select_pin(sel), .o_wr_valid(wr_valid), .o_wr(wr), .o_rd_req(rd_req),
		.i_rd_data(rd_data));
	pxs_host_model u_host (.o_scl_clk(scl), .o_pull_low(pull_low), .i_sda(sda));
	always @(posedge i_core_clk) begin
		if (!i_resetn) begin
			wr_n <= 0;
			rd_n <= 0;
		end else begin
			if (wr_valid === 1'b1) begin
				wr_n <= wr_n + 1;
				last_wr <= wr;
			end
			// A fresh byte after each fetch shows that every request refetches
			if (rd_req === 1'b1) begin
				rd_n <= rd_n + 1;
				rd_data <= rd_data + 8'h11;
			end
		end
	end
	task automatic chk(input string n, input logic [8:0] s, input logic [8:0] e);
		cmp_count++;
		if (s !== e) begin
			errors++;
			$display("ERROR %s exp %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic end_sim();
		$display("errors %0d compares %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : end_sim
	initial begin
		for (int i = 0; i < 4; i++) begin
			@(negedge i_core_clk);
			sel = rows[i][17];
			i_resetn = 1'b0;
			repeat (4) @(negedge i_core_clk);
			i_resetn = 1'b1;
			repeat (8) @(negedge i_core_clk);
			u_host.k = 1 + 3 * (i % 2);
			u_host.start();
			u_host.xfer({rows[i][16:9], 1'b1}, r);
			chk("addr ack", {8'h0, r[0]}, {8'h0, !rows[i][0]});
			u_host.xfer(9'h00f, r);
			u_host.xfer({rows[i][8:1], 1'b1}, r);
			chk("data ack", {8'h0, r[0]}, {8'h0, !rows[i][0]});
			u_host.stop();
			chk("bytes", 9'(wr_n), rows[i][0] ? 9'd2 : 9'd0);
			if (rows[i][0]) chk("byte", last_wr, {1'b0, rows[i][8:1]});
		end
		// Clocking with no start after a stop must draw no answer
		u_host.xfer(9'h105, r);
		chk("idle", r, 9'h105);
		chk("idle bytes", 9'(wr_n), 9'd2);
		u_host.start();
		u_host.xfer(9'h111, r);
		u_host.xfer(9'h0a1, r);
		u_host.start();
		u_host.xfer(9'h113, r);
		chk("read ack", {8'h0, r[0]}, 9'h0);
		chk("reg byte", last_wr, 9'h150);
		chk("tail bytes", 9'(wr_n), 9'd3);
		u_host.xfer(9'h1fe, r);
		chk("read 1", r, 9'h12c);
		u_host.xfer(9'h1ff, r);
		chk("read 2", r, 9'h14f);
		u_host.xfer(9'h1ff, r);
		chk("after nack", r, 9'h1ff);
		chk("rd reqs", 9'(rd_n), 9'd2);
		u_host.stop();
		end_sim();
	end
	initial begin
		#2_000_000;
		errors++;
		end_sim();
	end
endmodule : tb_pxs_slave
